// File: rtcta_regs.sv
/*
 * Calendar clock with alarm compare and its host register set:
 * time-of-day and date counters, alarm fields with don't-care
 * matching, and the time control register.
 * Assumes second_tick is a one-cycle pulse per second made from the
 * 32.768 kHz domain and already synchronous to clk, and that the
 * serial control interface presents single-cycle register strobes.
 */
// Notes on behaviour
// - Seconds in bits 6:0, 0-59, reset zero
// - Minutes in bits 14:8, 0-59, reset zero
// - Weekday bits 10:8, 1-7, Sunday one, reset one
// - Hours bits 4:0, 0-23 or 1-12, reset zero
// - Bit 5 flags PM in 12-hour mode
// - Month bits 12:8, 1-12, reset one
// - Day of month bits 5:0, 1-31, reset one
// - Century bits 13:8 fixed at twenty
// - Year bits 7:0, 0-99, reset zero
// - Alarm minutes; all ones always matches
// - Alarm seconds; all ones always matches
// - Alarm weekday four bits; all ones ignored
// - Alarm hours with PM flag; all ones ignored
// - Alarm month; all ones always matches
// - Alarm date; all ones always matches
// - Coding bit: zero binary, one BCD
// - Format bit: one 12-hour, zero 24-hour
// - Stop bit halts seconds; status reports it
// - Alarm stop bit and status, reset stopped
`timescale 1ns/1ns
module rtcta_regs (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        second_tick,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   output logic             alarm_event
);
   import rtcta_pkg::*;

   // ===================================================================
   // Storage
   logic [6:0] now_seconds;           // Current seconds
   logic [6:0] now_minutes;           // Current minutes
   logic [4:0] now_hours;             // Current hours
   logic       now_pm_flag;           // PM flag, or BCD tens bit in 24h
   logic [2:0] now_weekday;           // Day of week
   logic [5:0] now_day_of_month;      // Date
   logic [4:0] now_month;             // Month
   logic [7:0] now_year_in_century;   // Year within century
   logic [6:0] wake_seconds;          // Alarm seconds
   logic [6:0] wake_minutes;          // Alarm minutes
   logic [4:0] wake_hours;            // Alarm hours
   logic       wake_pm_flag;          // Alarm PM flag
   logic [3:0] wake_weekday;          // Alarm weekday
   logic [5:0] wake_day_of_month;     // Alarm date
   logic [4:0] wake_month;            // Alarm month
   logic       bcd_select;            // Coding of all time fields
   logic       twelve_hour_select;    // Clock format
   logic       counter_stop;          // Host request to stop counting
   logic       counter_halted_status; // Counter actually stopped
   logic       wake_halt;             // Host request to stop alarms
   logic       wake_halted_status;    // Alarm circuit actually stopped
   logic       match_seen;            // Match state last cycle

   // ===================================================================
   // Register write decode
   wire wr_secmin  = reg_wr & (reg_addr == RTCTA_OFS_SECMIN);
   wire wr_hrsday  = reg_wr & (reg_addr == RTCTA_OFS_HRSDAY);
   wire wr_datmon  = reg_wr & (reg_addr == RTCTA_OFS_DATMON);
   wire wr_year    = reg_wr & (reg_addr == RTCTA_OFS_YEAR);
   wire wr_wsecmin = reg_wr & (reg_addr == RTCTA_OFS_WSECMIN);
   wire wr_whrsday = reg_wr & (reg_addr == RTCTA_OFS_WHRSDAY);
   wire wr_wdatmon = reg_wr & (reg_addr == RTCTA_OFS_WDATMON);
   wire wr_ctrl    = reg_wr & (reg_addr == RTCTA_OFS_CTRL);

   // ===================================================================
   // Carry chain
   // Counting follows the actual halt state, not the raw request
   wire adv_sec = second_tick & ~counter_halted_status;
   wire sec_wrap;
   wire min_wrap;
   wire hr_wrap;
   wire date_wrap;
   wire mon_wrap;
   wire adv_min  = adv_sec & sec_wrap;
   wire adv_hr   = adv_min & min_wrap;
   wire adv_date = adv_hr & hr_wrap;
   wire adv_mon  = adv_date & date_wrap;
   wire adv_yr   = adv_mon & mon_wrap;

   wire [7:0] sec_nxt;
   wire [7:0] min_nxt;
   wire [7:0] date_nxt;
   wire [7:0] mon_nxt;
   wire [7:0] yr_nxt;
   wire [7:0] day_nxt;

   // Month length needs month and year in binary
   wire [7:0] mon_bin  = bcd_select ? code2bin({3'h0, now_month})
                                    : {3'h0, now_month};
   wire [7:0] yr_bin   = bcd_select ? code2bin(now_year_in_century)
                                    : now_year_in_century;
   wire [7:0] date_max = days_in_month(mon_bin, yr_bin);

   // ===================================================================
   // Field steppers
   rtcta_field_step u_sec (
      .val ({1'b0, now_seconds}), .lo (RTCTA_ZERO), .hi (RTCTA_SEC_MAX),
      .bcd (bcd_select), .nxt (sec_nxt), .wrap (sec_wrap));
   rtcta_field_step u_min (
      .val ({1'b0, now_minutes}), .lo (RTCTA_ZERO), .hi (RTCTA_SEC_MAX),
      .bcd (bcd_select), .nxt (min_nxt), .wrap (min_wrap));
   rtcta_field_step u_date (
      .val ({2'h0, now_day_of_month}), .lo (RTCTA_ONE), .hi (date_max),
      .bcd (bcd_select), .nxt (date_nxt), .wrap (date_wrap));
   rtcta_field_step u_mon (
      .val ({3'h0, now_month}), .lo (RTCTA_ONE), .hi (RTCTA_MON_MAX),
      .bcd (bcd_select), .nxt (mon_nxt), .wrap (mon_wrap));
   rtcta_field_step u_yr (
      .val (now_year_in_century), .lo (RTCTA_ZERO), .hi (RTCTA_YR_MAX),
      .bcd (bcd_select), .nxt (yr_nxt), .wrap ());
   // Weekday digits are the same in both codings; its wrap is not needed
   rtcta_field_step u_day (
      .val ({5'h00, now_weekday}), .lo (RTCTA_ONE), .hi (RTCTA_DAY_MAX),
      .bcd (1'b0), .nxt (day_nxt), .wrap ());

   // ===================================================================
   // Hours step
   // In 24-hour mode bit 5 is the top of the hour code, which stays
   // zero in binary and carries the tens bit for BCD 20 to 23
   wire [7:0] hr_code = twelve_hour_select ? {3'h0, now_hours}
                                           : {2'h0, now_pm_flag, now_hours};
   wire [7:0] hr_bin  = bcd_select ? code2bin(hr_code) : hr_code;
   logic [7:0] next_hr_bin;   // Next hour, binary
   logic       next_pm;       // Next PM flag in 12-hour mode

   always_comb begin
      next_hr_bin = 8'(hr_bin + 8'h01);
      next_pm     = now_pm_flag;
      if (!twelve_hour_select) begin
         // 23 rolls to 0 and carries into the date
         if (hr_bin >= RTCTA_HR24_MAX) begin
            next_hr_bin = RTCTA_ZERO;
         end
      end else if (hr_bin == RTCTA_HR12_EVE) begin
         // 11 to 12 flips AM and PM
         next_pm = ~now_pm_flag;
      end else if (hr_bin >= RTCTA_HR12_MAX) begin
         // 12 rolls to 1 with no flag change
         next_hr_bin = RTCTA_ONE;
      end
   end

   // Date advances at midnight in either format
   assign hr_wrap = twelve_hour_select
                    ? ((hr_bin == RTCTA_HR12_EVE) & now_pm_flag)
                    : (hr_bin >= RTCTA_HR24_MAX);
   wire [7:0] hr_nxt = bin2code(next_hr_bin, bcd_select);

   // ===================================================================
   // Seconds and minutes
   // A host write wins over the tick for the register it targets
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         now_seconds <= RTCTA_RST_SEC;
         now_minutes <= RTCTA_RST_MIN;
      end else if (wr_secmin) begin
         now_seconds <= reg_wdata[RTCTA_POS_SEC +: 7];
         now_minutes <= reg_wdata[RTCTA_POS_MIN +: 7];
      end else begin
         if (adv_sec) begin
            now_seconds <= sec_nxt[6:0];
         end
         if (adv_min) begin
            now_minutes <= min_nxt[6:0];
         end
      end
   end

   // ===================================================================
   // Hours and weekday
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         now_hours   <= RTCTA_RST_HRS;
         now_pm_flag <= 1'b0;
         now_weekday <= RTCTA_RST_DAY;
      end else if (wr_hrsday) begin
         now_hours   <= reg_wdata[RTCTA_POS_HRS +: 5];
         // Binary 24-hour never needs bit 5
         now_pm_flag <= reg_wdata[RTCTA_POS_PM]
                        & (twelve_hour_select | bcd_select);
         now_weekday <= reg_wdata[RTCTA_POS_DAY +: 3];
      end else begin
         if (adv_hr) begin
            now_hours   <= hr_nxt[4:0];
            now_pm_flag <= twelve_hour_select ? next_pm : hr_nxt[5];
         end else if (!twelve_hour_select && !bcd_select) begin
            now_pm_flag <= 1'b0;
         end
         if (adv_date) begin
            now_weekday <= day_nxt[2:0];
         end
      end
   end

   // ===================================================================
   // Date, month and year
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         now_day_of_month    <= RTCTA_RST_DATE;
         now_month           <= RTCTA_RST_MON;
         now_year_in_century <= RTCTA_RST_YR;
      end else begin
         if (wr_datmon) begin
            now_day_of_month <= reg_wdata[RTCTA_POS_DATE +: 6];
            now_month        <= reg_wdata[RTCTA_POS_MON +: 5];
         end else begin
            if (adv_date) begin
               now_day_of_month <= date_nxt[5:0];
            end
            if (adv_mon) begin
               now_month <= mon_nxt[4:0];
            end
         end
         // Only the year part of its register is writable
         if (wr_year) begin
            now_year_in_century <= reg_wdata[RTCTA_POS_YR +: 8];
         end else if (adv_yr) begin
            now_year_in_century <= yr_nxt;
         end
      end
   end

   // ===================================================================
   // Alarm fields
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wake_seconds      <= RTCTA_RST_SEC;
         wake_minutes      <= RTCTA_RST_MIN;
         wake_hours        <= RTCTA_RST_HRS;
         wake_pm_flag      <= 1'b0;
         wake_weekday      <= RTCTA_RST_WDAY;
         wake_day_of_month <= RTCTA_RST_WDATE;
         wake_month        <= RTCTA_RST_WMON;
      end else begin
         if (wr_wsecmin) begin
            wake_seconds <= reg_wdata[RTCTA_POS_SEC +: 7];
            wake_minutes <= reg_wdata[RTCTA_POS_MIN +: 7];
         end
         // PM flag stored as written; the host owns its 24-hour value
         if (wr_whrsday) begin
            wake_hours   <= reg_wdata[RTCTA_POS_HRS +: 5];
            wake_pm_flag <= reg_wdata[RTCTA_POS_PM];
            wake_weekday <= reg_wdata[RTCTA_POS_DAY +: 4];
         end
         if (wr_wdatmon) begin
            wake_day_of_month <= reg_wdata[RTCTA_POS_DATE +: 6];
            wake_month        <= reg_wdata[RTCTA_POS_MON +: 5];
         end
      end
   end

   // ===================================================================
   // Time control
   // Status bits trail their requests by one cycle so software can
   // poll for the moment the circuit has really stopped
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bcd_select            <= 1'b0;
         twelve_hour_select    <= 1'b0;
         counter_stop          <= 1'b0;
         counter_halted_status <= 1'b0;
         wake_halt             <= RTCTA_RST_WHALT;
         wake_halted_status    <= RTCTA_RST_WHALT;
      end else begin
         if (wr_ctrl) begin
            bcd_select         <= reg_wdata[RTCTA_POS_BCD];
            twelve_hour_select <= reg_wdata[RTCTA_POS_12H];
            counter_stop       <= reg_wdata[RTCTA_POS_STOP];
            wake_halt          <= reg_wdata[RTCTA_POS_WHALT];
         end
         counter_halted_status <= counter_stop;
         wake_halted_status    <= wake_halt;
      end
   end

   // ===================================================================
   // Alarm compare
   // An all-ones field is a wildcard for its comparison
   wire m_sec  = (&wake_seconds) | (wake_seconds == now_seconds);
   wire m_min  = (&wake_minutes) | (wake_minutes == now_minutes);
   wire m_day  = (&wake_weekday)
                 | (wake_weekday == {1'b0, now_weekday});
   wire m_date = (&wake_day_of_month)
                 | (wake_day_of_month == now_day_of_month);
   wire m_mon  = (&wake_month) | (wake_month == now_month);
   // PM flag takes part in every mode; in 24-hour mode it must follow
   // the host's rule so that it equals the stored bit 5
   wire m_hr   = (&wake_hours)
                 | ((wake_hours == now_hours)
                    & (wake_pm_flag == now_pm_flag));
   wire all_match = m_sec & m_min & m_hr & m_day & m_date & m_mon;

   // One pulse per new match; a match held over a second fires once.
   // Rewriting alarm fields with alarms running may fire falsely.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         match_seen  <= 1'b0;
         alarm_event <= 1'b0;
      end else begin
         match_seen  <= all_match;
         alarm_event <= all_match & ~match_seen
                        & ~wake_halted_status;
      end
   end

   // ===================================================================
   // Read path
   logic [15:0] rd_mux;   // Selected register image
   // Century is a constant, only its coding follows the select bit
   wire [7:0] cent_code = bin2code({2'h0, RTCTA_CENTURY}, bcd_select);

   always_comb begin
      rd_mux = 16'h0000;
      case (reg_addr)
         RTCTA_OFS_SECMIN:  rd_mux = {1'b0, now_minutes, 1'b0, now_seconds};
         RTCTA_OFS_HRSDAY:  rd_mux = {5'h00, now_weekday, 2'h0,
                                      now_pm_flag, now_hours};
         RTCTA_OFS_DATMON:  rd_mux = {3'h0, now_month, 2'h0, now_day_of_month};
         // Century reads as twenty in the current coding
         RTCTA_OFS_YEAR:    rd_mux = {2'h0, cent_code[5:0], now_year_in_century};
         RTCTA_OFS_WSECMIN: rd_mux = {1'b0, wake_minutes, 1'b0, wake_seconds};
         RTCTA_OFS_WHRSDAY: rd_mux = {4'h0, wake_weekday, 2'h0,
                                      wake_pm_flag, wake_hours};
         RTCTA_OFS_WDATMON: rd_mux = {3'h0, wake_month, 2'h0, wake_day_of_month};
         RTCTA_OFS_CTRL:    rd_mux = {bcd_select, twelve_hour_select, 2'h0,
                                      counter_stop, counter_halted_status,
                                      wake_halt, wake_halted_status, 8'h00};
         default:           rd_mux = 16'h0000;   // Unmapped reads zero
      endcase
   end

   // Read data is registered and held until the next read
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_mux;
         end
      end
   end

endmodule : rtcta_regs

// File: rtcta_pkg.sv
/*
 * Package for the calendar clock and alarm register block: register
 * offsets, field positions, reset values, counting limits and the
 * coding helpers shared by the counter and its field stepper.
 * Assumes registers are 16 bits wide and addressed by an 8-bit index.
 */
package rtcta_pkg;

   // ===================================================================
   // Register offsets
   localparam logic [7:0] RTCTA_OFS_SECMIN  = 8'h10; // Seconds/minutes
   localparam logic [7:0] RTCTA_OFS_HRSDAY  = 8'h11; // Hours/weekday
   localparam logic [7:0] RTCTA_OFS_DATMON  = 8'h12; // Date/month
   localparam logic [7:0] RTCTA_OFS_YEAR    = 8'h13; // Century/year
   localparam logic [7:0] RTCTA_OFS_WSECMIN = 8'h14; // Alarm sec/min
   localparam logic [7:0] RTCTA_OFS_WHRSDAY = 8'h15; // Alarm hrs/day
   localparam logic [7:0] RTCTA_OFS_WDATMON = 8'h16; // Alarm date/month
   localparam logic [7:0] RTCTA_OFS_CTRL    = 8'h17; // Time control

   // ===================================================================
   // Field positions
   localparam int RTCTA_POS_SEC      = 0;
   localparam int RTCTA_POS_MIN      = 8;
   localparam int RTCTA_POS_HRS      = 0;
   localparam int RTCTA_POS_PM       = 5;
   localparam int RTCTA_POS_DAY      = 8;
   localparam int RTCTA_POS_DATE     = 0;
   localparam int RTCTA_POS_MON      = 8;
   localparam int RTCTA_POS_YR       = 0;
   localparam int RTCTA_POS_CENT     = 8;
   localparam int RTCTA_POS_BCD      = 15;
   localparam int RTCTA_POS_12H      = 14;
   localparam int RTCTA_POS_STOP     = 11;
   localparam int RTCTA_POS_STOPSTS  = 10;
   localparam int RTCTA_POS_WHALT    = 9;
   localparam int RTCTA_POS_WHALTSTS = 8;

   // ===================================================================
   // Reset values
   localparam logic [6:0] RTCTA_RST_SEC   = 7'h00;
   localparam logic [6:0] RTCTA_RST_MIN   = 7'h00;
   localparam logic [4:0] RTCTA_RST_HRS   = 5'h00;
   localparam logic [2:0] RTCTA_RST_DAY   = 3'h1;
   localparam logic [5:0] RTCTA_RST_DATE  = 6'h01;
   localparam logic [4:0] RTCTA_RST_MON   = 5'h01;
   localparam logic [7:0] RTCTA_RST_YR    = 8'h00;
   localparam logic [5:0] RTCTA_CENTURY   = 6'h14;  // Decimal twenty
   localparam logic [3:0] RTCTA_RST_WDAY  = 4'h0;
   localparam logic [5:0] RTCTA_RST_WDATE = 6'h00;
   localparam logic [4:0] RTCTA_RST_WMON  = 5'h00;
   localparam logic       RTCTA_RST_WHALT = 1'b1;   // Alarms start stopped

   // ===================================================================
   // Counting limits, binary
   localparam logic [7:0] RTCTA_SEC_MAX  = 8'h3B;   // 59
   localparam logic [7:0] RTCTA_HR24_MAX = 8'h17;   // 23
   localparam logic [7:0] RTCTA_HR12_MAX = 8'h0C;   // 12
   localparam logic [7:0] RTCTA_HR12_EVE = 8'h0B;   // 11, PM flips after
   localparam logic [7:0] RTCTA_DAY_MAX  = 8'h07;
   localparam logic [7:0] RTCTA_MON_MAX  = 8'h0C;
   localparam logic [7:0] RTCTA_YR_MAX   = 8'h63;   // 99
   localparam logic [7:0] RTCTA_ZERO     = 8'h00;
   localparam logic [7:0] RTCTA_ONE      = 8'h01;

   // ===================================================================
   // Coding helpers
   // Two BCD digits to binary
   function automatic logic [7:0] code2bin(input logic [7:0] v);
      code2bin = 8'(v[7:4] * 8'h0A) + {4'h0, v[3:0]};
   endfunction : code2bin

   // Binary to the selected coding
   function automatic logic [7:0] bin2code(input logic [7:0] b,
                                           input logic       bcd);
      bin2code = bcd ? {4'(b / 8'h0A), 4'(b % 8'h0A)} : b;
   endfunction : bin2code

   // Length of a month; the century is fixed so every fourth year leaps
   function automatic logic [7:0] days_in_month(input logic [7:0] m,
                                                input logic [7:0] y);
      case (m)
         8'h02:   days_in_month = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
         8'h04,
         8'h06,
         8'h09,
         8'h0B:   days_in_month = 8'h1E;
         default: days_in_month = 8'h1F;
      endcase
   endfunction : days_in_month

endpackage : rtcta_pkg

// File: rtcta_field_step.sv
/*
 * One calendar field advanced by one step, wrapping from its upper
 * limit to its lower limit, in binary or BCD coding.
 * Assumes limits are given in binary and the field value in the
 * selected coding, zero-padded to eight bits.
 */
`timescale 1ns/1ns
module rtcta_field_step (
   input  wire logic [7:0] val,
   input  wire logic [7:0] lo,
   input  wire logic [7:0] hi,
   input  wire logic       bcd,
   output logic      [7:0] nxt,
   output logic            wrap
);
   import rtcta_pkg::*;

   logic [7:0] cur_bin;   // Field value in binary

   // ===================================================================
   // Step
   assign cur_bin = bcd ? code2bin(val) : val;
   // At or above the limit wraps, so a bad host value self-corrects
   assign wrap = (cur_bin >= hi);
   assign nxt  = wrap ? bin2code(lo, bcd)
                      : bin2code(8'(cur_bin + 8'h01), bcd);

endmodule : rtcta_field_step

// File: rtcta_props.sv
/* Checker for the clock register block ports.
   Assumes it is bound to rtcta_regs with reads answered next cycle. */
`timescale 1ns/1ns
module rtcta_props
   import rtcta_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        second_tick,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        alarm_event
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // Read answer, pulse width and range checks; ceilings allow BCD coding too
   sequence rd_of(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence
   chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   chk_ev_single: assert property (alarm_event |=> !alarm_event)
      else $error("alarm pulse too long");
   chk_sec_range: assert property (rd_of(RTCTA_OFS_SECMIN) |=> reg_rdata[6:0] <= 7'h59)
      else $error("seconds out of range");
   chk_min_range: assert property (rd_of(RTCTA_OFS_SECMIN) |=> reg_rdata[14:8] <= 7'h59)
      else $error("minutes out of range");
   chk_day_range: assert property (rd_of(RTCTA_OFS_HRSDAY) |=> reg_rdata[10:8] != 3'h0)
      else $error("weekday zero");
   chk_date_nonzero: assert property (rd_of(RTCTA_OFS_DATMON) |=> reg_rdata[5:0] != 6'h00)
      else $error("date zero");
   chk_cent_fixed: assert property (rd_of(RTCTA_OFS_YEAR)
      |=> reg_rdata[13:8] inside {6'h14, 6'h20})
      else $error("century changed");
   chk_year_range: assert property (rd_of(RTCTA_OFS_YEAR) |=> reg_rdata[7:0] <= 8'h99)
      else $error("year out of range");
endmodule : rtcta_props
bind rtcta_regs rtcta_props chk (.clk(clk), .sys_rst(sys_rst), .second_tick(second_tick),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alarm_event(alarm_event));

// File: rtcta_host.sv
/* Host model: single-cycle register strobes at the falling edge.
   Assumes the bench supplies clk. */
`timescale 1ns/1ns
module rtcta_host (
   input  wire logic        clk,
   output logic      [7:0]  reg_addr = 8'h00,
   output logic      [15:0] reg_wdata = 16'h0000,
   output logic             reg_wr = 1'b0,
   output logic             reg_rd = 1'b0
);
   // Write; data inverted after so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   // Read strobe; answer is due at the falling edge it returns on
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
   endtask : rd
endmodule : rtcta_host

// File: testbench.sv
/* Bench for the clock register block.
   Assumes rtcta_host drives the register strobes. */
`timescale 1ns/1ns
module testbench;
   import rtcta_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        second_tick = 1'b0;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd, reg_rvalid, alarm_event;
   int          miscompares = 0;
   int          checked = 0;
   logic [15:0] rst_tab [9] = '{16'h0, 16'h0100, 16'h0101, 16'h1400, 16'h0, 16'h0, 16'h0,
                                16'h0300, 16'h0};
   rtcta_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
                    .reg_rd(reg_rd));
   rtcta_regs uut (.clk(clk), .sys_rst(sys_rst), .second_tick(second_tick),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alarm_event(alarm_event));
   initial forever #2 clk = ~clk;
   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   // Read one register, bounded wait for the answer, then compare
   task automatic chk(input logic [7:0] a, input logic [15:0] e);
      int i;
      host.rd(a);
      for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk);
      checked++;
      if (reg_rvalid !== 1'b1 || reg_rdata !== e) begin
         miscompares++;
         $display("[FAIL] %0t reg %h read %h want %h", $time, a, reg_rdata, e);
      end
      if (reg_rvalid !== 1'b1) test_done();
   endtask : chk
   // One second tick, then watch four cycles for the alarm pulse
   task automatic tick_alarm(input logic e);
      logic seen;
      seen = 1'b0;
      second_tick = 1'b1;
      @(negedge clk);
      second_tick = 1'b0;
      repeat (4) @(negedge clk) seen = seen | (alarm_event === 1'b1);
      checked++;
      if (seen !== e) begin
         miscompares++;
         $display("[FAIL] %0t alarm pulse %b want %b", $time, seen, e);
      end
   endtask : tick_alarm
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      foreach (rst_tab[k]) chk(8'(8'h10 + k), rst_tab[k]);
      host.wr(8'h18, 16'hFFFF);
      chk(8'h18, 16'h0000);
      host.wr(RTCTA_OFS_YEAR, 16'h3F63);
      chk(RTCTA_OFS_YEAR, 16'h1463);
      $display("reset and map test done");
      host.wr(RTCTA_OFS_CTRL, 16'h0200);
      host.wr(RTCTA_OFS_WSECMIN, 16'h7F00);
      host.wr(RTCTA_OFS_WHRSDAY, 16'h0F3F);
      host.wr(RTCTA_OFS_WDATMON, 16'h1F3F);
      host.wr(RTCTA_OFS_SECMIN, 16'h3B3B);
      host.wr(RTCTA_OFS_HRSDAY, 16'h0717);
      host.wr(RTCTA_OFS_DATMON, 16'h0C1F);
      host.wr(RTCTA_OFS_CTRL, 16'h0000);
      tick_alarm(1'b1);
      tick_alarm(1'b0);
      chk(RTCTA_OFS_SECMIN, 16'h0001);
      chk(RTCTA_OFS_HRSDAY, 16'h0100);
      chk(RTCTA_OFS_DATMON, 16'h0101);
      chk(RTCTA_OFS_YEAR, 16'h1400);
      $display("rollover test done");
      host.wr(RTCTA_OFS_CTRL, 16'h0800);
      chk(RTCTA_OFS_CTRL, 16'h0C00);
      tick_alarm(1'b0);
      chk(RTCTA_OFS_SECMIN, 16'h0001);
      host.wr(RTCTA_OFS_CTRL, 16'hC000);
      host.wr(RTCTA_OFS_HRSDAY, 16'h0131);
      host.wr(RTCTA_OFS_SECMIN, 16'h5959);
      tick_alarm(1'b1);
      chk(RTCTA_OFS_HRSDAY, 16'h0212);
      chk(RTCTA_OFS_DATMON, 16'h0102);
      $display("stop and twelve hour test done");
      host.wr(RTCTA_OFS_CTRL, 16'hC200);
      host.wr(RTCTA_OFS_WSECMIN, 16'h0101);
      host.wr(RTCTA_OFS_WHRSDAY, 16'h0312);
      host.wr(RTCTA_OFS_WDATMON, 16'h0102);
      host.wr(RTCTA_OFS_SECMIN, 16'h0100);
      host.wr(RTCTA_OFS_CTRL, 16'hC000);
      tick_alarm(1'b0);
      host.wr(RTCTA_OFS_CTRL, 16'hC200);
      host.wr(RTCTA_OFS_WHRSDAY, 16'h0232);
      host.wr(RTCTA_OFS_SECMIN, 16'h0100);
      host.wr(RTCTA_OFS_CTRL, 16'hC000);
      tick_alarm(1'b0);
      host.wr(RTCTA_OFS_CTRL, 16'hC200);
      host.wr(RTCTA_OFS_WHRSDAY, 16'h0212);
      host.wr(RTCTA_OFS_SECMIN, 16'h0100);
      tick_alarm(1'b0);
      host.wr(RTCTA_OFS_CTRL, 16'hC000);
      host.wr(RTCTA_OFS_SECMIN, 16'h0100);
      tick_alarm(1'b1);
      $display("alarm field test done");
      test_done();
   end
endmodule : testbench
